// File: cpm_clock_power_ctrl.v
// Behaviour
// - Low voltage holds internal reset, detector excluded.
// - Supply recovery releases reset, program restarts.
// - Detector changes state after 5us persistence.
// - Detector enable comes from its option byte.
// - Three thresholds selectable by option byte.
// - Detector inactive while in halt mode.
// - Wait stops only CPU clock.
// - Interrupt or reset ends wait mode.
// - Halt stops the oscillator and everything.
// - Halt ignored while watchdog is enabled.
// - Halt exits on NMI, unmasked port, reset.
// - Halt exit restarts oscillator, counts 4096.
// - External source adds 4096 times prescaler plus one.
// - Wake source interrupt is served first.
// - Divider code: zero, one-hot, others 64.
// - Source bit: 0 internal, 1 external.
// - Gain field decodes 0,1,3,6,8 stages.
// - Trim above 40 stops internal oscillator.
// - Every start runs internal oscillator first.
// - Wake prescaler is an eight-bit option.
// - CPU and peripheral clocks; divider on CPU only.
//
// Implementation choice: register access over APB.
`timescale 1ns/1ns
`include "cpm_defines.vh"

module cpm_clock_power_ctrl #(
    parameter [12:0] STAB_CYCLES = `CPM_STAB_CYCLES
) (
    input  wire        CORE_CLK_IN,
    input  wire        RESETN_IN,
    input  wire        PSEL_IN,
    input  wire        PENABLE_IN,
    input  wire        PWRITE_IN,
    input  wire [9:0]  PADDR_IN,
    input  wire [31:0] PWDATA_IN,
    output reg  [31:0] PRDATA_OUT,
    output reg         PREADY_OUT,
    output reg         PSLVERR_OUT,
    input  wire [7:0]  OPT_CLK_SRC_IN,
    input  wire [7:0]  OPT_GAIN_IN,
    input  wire [7:0]  OPT_TRIM_IN,
    input  wire [7:0]  OPT_LVD_IN,
    input  wire [7:0]  OPT_WAKE_IN,
    input  wire        VDD_BELOW_LOW_IN,
    input  wire        VDD_BELOW_MED_IN,
    input  wire        VDD_BELOW_HIGH_IN,
    input  wire        NMI_IN,
    input  wire [1:0]  PORT_IRQ_IN,
    input  wire [1:0]  PORT_IRQ_MASK_IN,
    input  wire        IRQ_ANY_IN,
    input  wire        WAIT_REQ_IN,
    input  wire        HALT_REQ_IN,
    input  wire        WDG_EN_IN,
    output reg         SYS_RESETN_OUT,
    output reg         CPU_CLK_EN_OUT,
    output reg         PERIPH_CLK_EN_OUT,
    output reg         INT_OSC_RUN_OUT,
    output reg         CLK_SEL_EXT_OUT,
    output reg  [3:0]  GAIN_STAGES_OUT,
    output reg  [5:0]  OSC_TRIM_OUT,
    output reg  [1:0]  LVD_LEVEL_OUT,
    output reg         LVD_EN_OUT,
    output reg         WAKE_SERVE_OUT,
    output reg  [1:0]  MODE_OUT
);

    localparam [2:0] ST_STAB1 = 3'h0;
    localparam [2:0] ST_STAB2 = 3'h1;
    localparam [2:0] ST_RUN   = 3'h2;
    localparam [2:0] ST_WAIT  = 3'h3;
    localparam [2:0] ST_HALT  = 3'h4;
    localparam [2:0] ST_LVD   = 3'h5;

    localparam integer FILT_INT =
        (`CPM_LVD_FILT_NS + `CPM_CLK_PERIOD_NS - 1) / `CPM_CLK_PERIOD_NS;
    localparam [7:0] FILT_CYC = FILT_INT[7:0];

    // Option bytes and comparators are outside this clock domain.
    reg  [39:0] opt_meta_r;
    reg  [39:0] opt_sync_r;
    reg  [5:0]  async_meta_r;
    reg  [5:0]  async_sync_r;

    always @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            opt_meta_r   <= 40'h0000000000;
            opt_sync_r   <= 40'h0000000000;
            async_meta_r <= 6'h00;
            async_sync_r <= 6'h00;
        end else begin
            opt_meta_r   <= {OPT_WAKE_IN, OPT_LVD_IN, OPT_TRIM_IN, OPT_GAIN_IN,
                             OPT_CLK_SRC_IN};
            opt_sync_r   <= opt_meta_r;
            async_meta_r <= {PORT_IRQ_IN, NMI_IN, VDD_BELOW_HIGH_IN,
                             VDD_BELOW_MED_IN, VDD_BELOW_LOW_IN};
            async_sync_r <= async_meta_r;
        end
    end

    wire       below_low_s  = async_sync_r[0];
    wire       below_med_s  = async_sync_r[1];
    wire       below_high_s = async_sync_r[2];
    wire       nmi_s        = async_sync_r[3];
    wire [1:0] port_irq_s   = async_sync_r[5:4];

    reg  [2:0]  state_r;
    reg  [12:0] cnt_r;
    reg  [7:0]  loop_r;
    reg         loaded_r;
    reg         boot_done_r;
    reg         wake_pend_r;
    reg  [7:0]  opt_src_r;
    reg  [7:0]  opt_gain_r;
    reg  [7:0]  opt_trim_r;
    reg  [7:0]  opt_lvd_r;
    reg  [7:0]  opt_wake_r;
    reg         lvd_state_r;
    reg  [7:0]  filt_cnt_r;
    reg  [5:0]  cpu_div_r;
    reg  [5:0]  div_cnt_r;

    wire cnt_end = (cnt_r == STAB_CYCLES - 13'h0001);
    // Bit 1 of the source byte is assumed zero and is not decoded.
    wire src_ext = loaded_r ? opt_src_r[`CPM_SRC_EXT_BIT]
                            : opt_sync_r[`CPM_SRC_EXT_BIT];
    wire [1:0] lvd_lvl = opt_lvd_r[1:0];
    wire lvd_en  = loaded_r && (lvd_lvl != `CPM_LVD_OFF);
    wire port_wake = |(port_irq_s & ~PORT_IRQ_MASK_IN);
    wire trim_bad = (opt_trim_r[5:0] > `CPM_TRIM_MAX);

    // Threshold comparator chosen by the detector option field.
    reg lvd_raw;
    always @* begin
        case (lvd_lvl)
            `CPM_LVD_LOWEST:  lvd_raw = below_low_s;
            `CPM_LVD_HIGHEST: lvd_raw = below_high_s;
            `CPM_LVD_MEDIUM:  lvd_raw = below_med_s;
            default:          lvd_raw = 1'b0;
        endcase
    end

    // Spike filter: the state only flips once the new level has held long enough.
    // Halt clears the count, so a stale count cannot fire right after wake-up.
    always @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            lvd_state_r <= 1'b0;
            filt_cnt_r  <= 8'h00;
        end else if (!lvd_en || state_r == ST_HALT) begin
            lvd_state_r <= 1'b0;
            filt_cnt_r  <= 8'h00;
        end else if (lvd_raw == lvd_state_r) begin
            filt_cnt_r <= 8'h00;
        end else if (filt_cnt_r == FILT_CYC - 8'h01) begin
            lvd_state_r <= lvd_raw;
            filt_cnt_r  <= 8'h00;
        end else begin
            filt_cnt_r <= filt_cnt_r + 8'h01;
        end
    end

    // Power mode sequencer.
    always @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            state_r     <= ST_STAB1;
            cnt_r       <= 13'h0000;
            loop_r      <= 8'h00;
            loaded_r    <= 1'b0;
            boot_done_r <= 1'b0;
            wake_pend_r <= 1'b0;
            opt_src_r   <= 8'h00;
            opt_gain_r  <= 8'h00;
            opt_trim_r  <= 8'h00;
            opt_lvd_r   <= 8'h00;
            opt_wake_r  <= 8'h00;
        end else if (lvd_state_r) begin
            // The oscillator stays on, so recovery needs no delay.
            state_r     <= ST_LVD;
            cnt_r       <= 13'h0000;
            wake_pend_r <= 1'b0;
        end else begin
            case (state_r)
                ST_STAB1: begin
                    if (cnt_end) begin
                        cnt_r  <= 13'h0000;
                        loop_r <= 8'h00;
                        // Latching once per power-up keeps a halt wake-up from taking new options.
                        if (!loaded_r) begin
                            loaded_r   <= 1'b1;
                            opt_src_r  <= opt_sync_r[7:0];
                            opt_gain_r <= opt_sync_r[15:8];
                            opt_trim_r <= opt_sync_r[23:16];
                            opt_lvd_r  <= opt_sync_r[31:24];
                            opt_wake_r <= opt_sync_r[39:32];
                        end
                        state_r <= src_ext ? ST_STAB2 : ST_RUN;
                    end else begin
                        cnt_r <= cnt_r + 13'h0001;
                    end
                end
                ST_STAB2: begin
                    if (cnt_end) begin
                        cnt_r <= 13'h0000;
                        if (loop_r == opt_wake_r) begin
                            state_r <= ST_RUN;
                        end else begin
                            loop_r <= loop_r + 8'h01;
                        end
                    end else begin
                        cnt_r <= cnt_r + 13'h0001;
                    end
                end
                ST_RUN: begin
                    boot_done_r <= 1'b1;
                    wake_pend_r <= 1'b0;
                    if (HALT_REQ_IN && !WDG_EN_IN) begin
                        state_r <= ST_HALT;
                    end else if (WAIT_REQ_IN && !HALT_REQ_IN) begin
                        state_r <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (IRQ_ANY_IN) begin
                        state_r <= ST_RUN;
                    end
                end
                ST_HALT: begin
                    if (nmi_s || port_wake) begin
                        wake_pend_r <= 1'b1;
                        cnt_r       <= 13'h0000;
                        state_r     <= ST_STAB1;
                    end
                end
                ST_LVD: begin
                    state_r <= ST_RUN;
                end
                default: begin
                    state_r <= ST_STAB1;
                end
            endcase
        end
    end

    // The divide mask is the factor minus one; code times two minus one
    // gives it for every one-hot code.
    reg [5:0] div_mask;
    always @* begin
        case (cpu_div_r)
            6'h00, 6'h01, 6'h02, 6'h04, 6'h08, 6'h10:
                div_mask = {cpu_div_r[4:0], 1'b0} - {5'h00, |cpu_div_r};
            6'h20:   div_mask = `CPM_DIV_MAX_MASK;
            default: div_mask = `CPM_DIV_MAX_MASK;
        endcase
    end

    // The counter runs free; a new code only shifts the phase of the next pulse.
    wire div_tick = (div_cnt_r >= div_mask);
    wire run_now  = (state_r == ST_RUN) && !lvd_state_r;
    // The core gets no clock until its reset is released, so it never steps
    // while SYS_RESETN_OUT is still low.
    wire cpu_run  = run_now && boot_done_r;
    // Peripherals follow the state, so they switch on the same edge as the mode code.
    wire periph_run = (state_r == ST_RUN) || (state_r == ST_WAIT);

    reg [3:0] stages;
    always @* begin
        case (opt_gain_r[2:0])
            `CPM_GAIN_NONE:  stages = `CPM_STAGES_0;
            `CPM_GAIN_ONE:   stages = `CPM_STAGES_1;
            `CPM_GAIN_THREE: stages = `CPM_STAGES_3;
            `CPM_GAIN_SIX:   stages = `CPM_STAGES_6;
            `CPM_GAIN_EIGHT: stages = `CPM_STAGES_8;
            default:         stages = `CPM_STAGES_0;
        endcase
    end

    reg [1:0] mode;
    always @* begin
        case (state_r)
            ST_RUN:  mode = `CPM_MODE_RUN;
            ST_WAIT: mode = `CPM_MODE_WAIT;
            ST_HALT: mode = `CPM_MODE_HALT;
            default: mode = `CPM_MODE_START;
        endcase
    end

    // Clock enables and control outputs, all registered.
    always @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            div_cnt_r         <= 6'h00;
            SYS_RESETN_OUT    <= 1'b0;
            CPU_CLK_EN_OUT    <= 1'b0;
            PERIPH_CLK_EN_OUT <= 1'b0;
            INT_OSC_RUN_OUT   <= 1'b0;
            CLK_SEL_EXT_OUT   <= 1'b0;
            GAIN_STAGES_OUT   <= 4'h0;
            OSC_TRIM_OUT      <= `CPM_TRIM_NOM;
            LVD_LEVEL_OUT     <= 2'h0;
            LVD_EN_OUT        <= 1'b0;
            WAKE_SERVE_OUT    <= 1'b0;
            MODE_OUT          <= `CPM_MODE_START;
        end else begin
            div_cnt_r         <= div_tick ? 6'h00 : div_cnt_r + 6'h01;
            SYS_RESETN_OUT    <= boot_done_r && !lvd_state_r && state_r != ST_LVD;
            CPU_CLK_EN_OUT    <= cpu_run && div_tick;
            PERIPH_CLK_EN_OUT <= periph_run;
            // Internal oscillator runs in ST_STAB1 or when selected, unless the trim is bad or the state is ST_HALT.
            INT_OSC_RUN_OUT   <= state_r != ST_HALT && !trim_bad
                                 && !(CLK_SEL_EXT_OUT && state_r != ST_STAB1);
            CLK_SEL_EXT_OUT   <= loaded_r && opt_src_r[`CPM_SRC_EXT_BIT]
                                 && state_r != ST_STAB1 && state_r != ST_HALT;
            GAIN_STAGES_OUT   <= stages;
            OSC_TRIM_OUT      <= loaded_r ? opt_trim_r[5:0] : `CPM_TRIM_NOM;
            LVD_LEVEL_OUT     <= lvd_lvl;
            LVD_EN_OUT        <= lvd_en && state_r != ST_HALT;
            WAKE_SERVE_OUT    <= wake_pend_r && state_r == ST_RUN;
            MODE_OUT          <= mode;
        end
    end

    // APB slave: data is prepared in the setup cycle, so access ends at once.
    wire       addr_ok = (PADDR_IN[1:0] == 2'h0);
    wire [7:0] idx     = PADDR_IN[9:2];
    reg  [7:0] rd_byte;
    reg        rd_hit;
    always @* begin
        rd_hit = addr_ok;
        case (idx)
            `CPM_IDX_CLK_SRC: rd_byte = opt_src_r;
            `CPM_IDX_GAIN:    rd_byte = opt_gain_r;
            `CPM_IDX_TRIM:    rd_byte = opt_trim_r;
            `CPM_IDX_LVD:     rd_byte = opt_lvd_r;
            `CPM_IDX_WAKE:    rd_byte = opt_wake_r;
            `CPM_IDX_CPU_DIV: rd_byte = {2'h0, cpu_div_r};
            `CPM_IDX_STATUS:  rd_byte = {trim_bad, loaded_r, lvd_en, lvd_state_r,
                                         CLK_SEL_EXT_OUT, wake_pend_r, mode};
            default: begin
                rd_byte = 8'h00;
                rd_hit  = 1'b0;
            end
        endcase
    end

    wire setup_ph  = PSEL_IN && !PENABLE_IN;
    wire wr_div    = addr_ok && idx == `CPM_IDX_CPU_DIV;
    // Writes to anything but the divider are refused and dropped.
    wire bad_acc   = PWRITE_IN ? !wr_div : !rd_hit;

    always @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            PRDATA_OUT  <= 32'h00000000;
            PREADY_OUT  <= 1'b0;
            PSLVERR_OUT <= 1'b0;
            cpu_div_r   <= `CPM_CPU_DIV_RST;
        end else begin
            PREADY_OUT <= setup_ph;
            if (setup_ph) begin
                PRDATA_OUT  <= (PWRITE_IN || !rd_hit) ? 32'h00000000
                                                      : {24'h000000, rd_byte};
                PSLVERR_OUT <= bad_acc;
            end else begin
                PSLVERR_OUT <= 1'b0;
            end
            // The write commits only at the access edge that shows ready high.
            if (PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN && wr_div) begin
                cpu_div_r <= PWDATA_IN[5:0];
            end
        end
    end

endmodule

// File: cpm_clock_power_ctrl_asserts.sv
`timescale 1ns/1ns
module cpm_clock_power_ctrl_asserts #(
    parameter [12:0] STAB_CYCLES = 13'h1000
) (
    input wire       CORE_CLK_IN,
    input wire       RESETN_IN,
    input wire       PSEL_IN,
    input wire       PENABLE_IN,
    input wire       PREADY_OUT,
    input wire       HALT_REQ_IN,
    input wire       WAIT_REQ_IN,
    input wire       WDG_EN_IN,
    input wire       SYS_RESETN_OUT,
    input wire       CPU_CLK_EN_OUT,
    input wire       PERIPH_CLK_EN_OUT,
    input wire       INT_OSC_RUN_OUT,
    input wire [3:0] GAIN_STAGES_OUT,
    input wire [5:0] OSC_TRIM_OUT,
    input wire       WAKE_SERVE_OUT,
    input wire [1:0] MODE_OUT
);
    default clocking cb @(posedge CORE_CLK_IN);
    endclocking
    default disable iff (!RESETN_IN);

    ready_single_a: assert property (PREADY_OUT |=> !PREADY_OUT)
        else $error("ready longer than one cycle");
    ready_setup_a: assert property (PSEL_IN && !PENABLE_IN |=> PREADY_OUT)
        else $error("no ready after setup");
    // Only requests made in a settled run cycle are judged, since a request one cycle
    // earlier may already have moved the sequencer on.
    halt_entry_a: assert property (MODE_OUT == 2'h1 && !$past(HALT_REQ_IN)
        && !$past(WAIT_REQ_IN) && HALT_REQ_IN && !WDG_EN_IN |-> ##2 MODE_OUT == 2'h3)
        else $error("halt not entered");
    wdg_skip_a: assert property (MODE_OUT == 2'h1 && !$past(HALT_REQ_IN)
        && !$past(WAIT_REQ_IN) && HALT_REQ_IN && WDG_EN_IN |-> ##2 MODE_OUT != 2'h3)
        else $error("halt taken with watchdog on");
    halt_quiet_a: assert property (MODE_OUT == 2'h3 && $past(MODE_OUT) == 2'h3
        |-> !INT_OSC_RUN_OUT && !PERIPH_CLK_EN_OUT && !CPU_CLK_EN_OUT)
        else $error("clocks alive in halt");
    wait_cpu_stop_a: assert property (MODE_OUT == 2'h2 && $past(MODE_OUT) == 2'h2
        |-> PERIPH_CLK_EN_OUT && !CPU_CLK_EN_OUT)
        else $error("wait clocks wrong");
    run_periph_a: assert property (MODE_OUT == 2'h1 && $past(MODE_OUT) == 2'h1
        |-> PERIPH_CLK_EN_OUT)
        else $error("peripheral clock off in run");
    core_reset_a: assert property (!SYS_RESETN_OUT
        |-> !CPU_CLK_EN_OUT && !WAKE_SERVE_OUT)
        else $error("core active in reset");
    gain_legal_a: assert property (GAIN_STAGES_OUT inside {4'h0, 4'h1, 4'h3, 4'h6, 4'h8})
        else $error("illegal gain stage count");
    trim_stop_a: assert property (OSC_TRIM_OUT > 6'h28 && $past(OSC_TRIM_OUT) > 6'h28
        |-> !INT_OSC_RUN_OUT)
        else $error("oscillator runs with bad trim");
endmodule

bind cpm_clock_power_ctrl cpm_clock_power_ctrl_asserts #(.STAB_CYCLES(STAB_CYCLES)) u_chk (
    .CORE_CLK_IN(CORE_CLK_IN), .RESETN_IN(RESETN_IN), .PSEL_IN(PSEL_IN),
    .PENABLE_IN(PENABLE_IN), .PREADY_OUT(PREADY_OUT), .HALT_REQ_IN(HALT_REQ_IN),
    .WAIT_REQ_IN(WAIT_REQ_IN), .WDG_EN_IN(WDG_EN_IN), .SYS_RESETN_OUT(SYS_RESETN_OUT),
    .CPU_CLK_EN_OUT(CPU_CLK_EN_OUT), .PERIPH_CLK_EN_OUT(PERIPH_CLK_EN_OUT),
    .INT_OSC_RUN_OUT(INT_OSC_RUN_OUT), .GAIN_STAGES_OUT(GAIN_STAGES_OUT),
    .OSC_TRIM_OUT(OSC_TRIM_OUT), .WAKE_SERVE_OUT(WAKE_SERVE_OUT), .MODE_OUT(MODE_OUT));

// File: cpm_core_model.sv
`timescale 1ns/1ns
// The core only steps on enable pulses, so counting them shows the ratio it really sees.
module cpm_core_model (
    input  wire clk_in,
    input  wire clr_in,
    input  wire win_in,
    input  wire cpu_en_in,
    input  wire wake_in,
    output int  ticks_out,
    output int  wakes_out
);
    always @(posedge clk_in) begin
        if (clr_in) begin
            ticks_out <= 0;
            wakes_out <= 0;
        end else begin
            if (win_in && cpu_en_in) ticks_out <= ticks_out + 1;
            if (wake_in) wakes_out <= wakes_out + 1;
        end
    end
endmodule

// File: cpm_defines.vh
`ifndef CPM_DEFINES_VH
`define CPM_DEFINES_VH

// Register indexes; the byte address on the bus is four times the index.
`define CPM_IDX_CLK_SRC   8'h00
`define CPM_IDX_GAIN      8'h01
`define CPM_IDX_TRIM      8'h02
`define CPM_IDX_LVD       8'h03
`define CPM_IDX_WAKE      8'h07
`define CPM_IDX_CPU_DIV   8'h2E
`define CPM_IDX_STATUS    8'h30

`define CPM_CPU_DIV_RST   6'h00
`define CPM_DIV_MAX_MASK  6'h3F

// Timing.
`define CPM_CLK_PERIOD_NS 100
`define CPM_LVD_FILT_NS   5000
`define CPM_STAB_CYCLES   13'h1000

// Option byte fields.
`define CPM_SRC_EXT_BIT   0
`define CPM_LVD_LOWEST    2'h0
`define CPM_LVD_HIGHEST   2'h1
`define CPM_LVD_OFF       2'h2
`define CPM_LVD_MEDIUM    2'h3
`define CPM_GAIN_NONE     3'h0
`define CPM_GAIN_ONE      3'h1
`define CPM_GAIN_THREE    3'h3
`define CPM_GAIN_SIX      3'h5
`define CPM_GAIN_EIGHT    3'h7
`define CPM_STAGES_0      4'h0
`define CPM_STAGES_1      4'h1
`define CPM_STAGES_3      4'h3
`define CPM_STAGES_6      4'h6
`define CPM_STAGES_8      4'h8
`define CPM_TRIM_MAX      6'h28
`define CPM_TRIM_NOM      6'h14

// Mode codes shown in status.
`define CPM_MODE_START    2'h0
`define CPM_MODE_RUN      2'h1
`define CPM_MODE_WAIT     2'h2
`define CPM_MODE_HALT     2'h3

`endif

// File: test_clock_power_mode_control.sv
`timescale 1ns/1ns
module test_clock_power_mode_control;
    logic clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, vlow = 0, nmi = 0, wreq = 0;
    logic hreq = 0, wdg = 0, irq = 0, win = 0, clr = 0, pready, pslverr, err;
    logic vmed = 0, vhigh = 0;
    logic sys_rstn, cpu_en, per_en, osc_run, clk_ext, lvd_en, wake_sv;
    logic [9:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [7:0] o_src = 0, o_gain = 0, o_trim = 8'h14, o_lvd = 0, o_wake = 0;
    logic [1:0] pirq = 0, pmask = 0, lvl, mode;
    logic [3:0] stages;
    logic [5:0] trim;
    int bad_count = 0, checks = 0, cyc = 0, ticks, wakes, lat, n;
    int codes[9] = '{0, 1, 2, 4, 8, 16, 32, 3, 63};
    int facts[9] = '{1, 2, 4, 8, 16, 32, 64, 64, 64};
    int gtab[8] = '{0, 1, 0, 3, 0, 6, 0, 8};

    cpm_clock_power_ctrl #(.STAB_CYCLES(13'h0010)) dut (
        .CORE_CLK_IN(clk), .RESETN_IN(rstn), .PSEL_IN(psel), .PENABLE_IN(pen),
        .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .OPT_CLK_SRC_IN(o_src),
        .OPT_GAIN_IN(o_gain), .OPT_TRIM_IN(o_trim), .OPT_LVD_IN(o_lvd), .OPT_WAKE_IN(o_wake),
        .VDD_BELOW_LOW_IN(vlow), .VDD_BELOW_MED_IN(vmed), .VDD_BELOW_HIGH_IN(vhigh),
        .NMI_IN(nmi), .PORT_IRQ_IN(pirq), .PORT_IRQ_MASK_IN(pmask), .IRQ_ANY_IN(irq),
        .WAIT_REQ_IN(wreq), .HALT_REQ_IN(hreq), .WDG_EN_IN(wdg), .SYS_RESETN_OUT(sys_rstn),
        .CPU_CLK_EN_OUT(cpu_en), .PERIPH_CLK_EN_OUT(per_en), .INT_OSC_RUN_OUT(osc_run),
        .CLK_SEL_EXT_OUT(clk_ext), .GAIN_STAGES_OUT(stages), .OSC_TRIM_OUT(trim),
        .LVD_LEVEL_OUT(lvl), .LVD_EN_OUT(lvd_en), .WAKE_SERVE_OUT(wake_sv), .MODE_OUT(mode));

    cpm_core_model core (.clk_in(clk), .clr_in(clr), .win_in(win), .cpu_en_in(cpu_en),
        .wake_in(wake_sv), .ticks_out(ticks), .wakes_out(wakes));

    always #50 clk = ~clk;

    task final_report;
        if (bad_count == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            final_report;
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task tick(input int k);
        repeat (k) @(posedge clk);
    endtask

    // Read data and the error flag are taken at the edge that sees ready high.
    task apb(input logic w, input logic [9:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1);
        chk(k, 1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask

    task rd_chk(input logic [9:0] a, input logic [31:0] exp, input logic experr);
        apb(1'b0, a, 32'h0);
        chk(err, experr);
        if (!experr) chk(rd, exp);
    endtask

    task pulse_req(input logic h);
        if (h)
            hreq <= 1'b1;
        else
            wreq <= 1'b1;
        tick(1);
        hreq <= 1'b0;
        wreq <= 1'b0;
        tick(3);
    endtask

    task do_reset(input logic [7:0] s, g, t, l);
        rstn <= 1'b0;
        o_src <= s;
        o_gain <= g;
        o_trim <= t;
        o_lvd <= l;
        o_wake <= 8'h01;
        tick(2);
        rstn <= 1'b1;
        tick(2);
        chk(clk_ext, 0);
        chk(osc_run, 1);
        lat = 2;
        while (sys_rstn !== 1'b1 && lat < 400) begin
            @(posedge clk);
            lat++;
        end
    endtask

    initial begin
        do_reset(8'h00, 8'h03, 8'h14, 8'h00);
        chk(lat >= 16 && lat <= 24, 1);
        rd_chk(10'h000, 32'h0, 0);
        rd_chk(10'h004, 32'h3, 0);
        rd_chk(10'h008, 32'h14, 0);
        rd_chk(10'h00C, 32'h0, 0);
        rd_chk(10'h01C, 32'h1, 0);
        rd_chk(10'h0B8, 32'h0, 0);
        rd_chk(10'h0C0, 32'h61, 0);
        rd_chk(10'h010, 32'h0, 1);
        rd_chk(10'h0BA, 32'h0, 1);
        apb(1'b1, 10'h004, 32'h5);
        chk(err, 1);
        o_gain <= 8'h07;
        tick(4);
        chk(stages, 3);
        rd_chk(10'h004, 32'h3, 0);
        for (int i = 0; i < 9; i++) begin
            apb(1'b1, 10'h0B8, codes[i]);
            rd_chk(10'h0B8, codes[i], 0);
            clr <= 1'b1;
            tick(64);
            clr <= 1'b0;
            win <= 1'b1;
            tick(128);
            win <= 1'b0;
            tick(1);
            chk(ticks, 128 / facts[i]);
        end
        apb(1'b1, 10'h0B8, 32'h0);
        wdg <= 1'b1;
        pulse_req(1'b1);
        chk(mode, 1);
        wdg <= 1'b0;
        pulse_req(1'b1);
        chk(mode, 3);
        vlow <= 1'b1;
        tick(60);
        chk(mode, 3);
        vlow <= 1'b0;
        pmask <= 2'b01;
        pirq <= 2'b01;
        tick(8);
        chk(mode, 3);
        pirq <= 2'b00;
        clr <= 1'b1;
        tick(1);
        clr <= 1'b0;
        nmi <= 1'b1;
        for (n = 0; n < 60 && mode !== 2'h1; n++) tick(1);
        nmi <= 1'b0;
        chk(n >= 16 && n <= 26, 1);
        tick(3);
        chk(wakes, 1);
        pulse_req(1'b1);
        pirq <= 2'b10;
        for (n = 0; n < 60 && mode !== 2'h1; n++) tick(1);
        pirq <= 2'b00;
        chk(mode, 1);
        pulse_req(1'b0);
        chk(mode, 2);
        chk(per_en, 1);
        irq <= 1'b1;
        tick(1);
        irq <= 1'b0;
        tick(3);
        chk(mode, 1);
        vmed <= 1'b1;
        vhigh <= 1'b1;
        tick(60);
        chk(sys_rstn, 1);
        vmed <= 1'b0;
        vhigh <= 1'b0;
        vlow <= 1'b1;
        tick(30);
        vlow <= 1'b0;
        tick(5);
        chk(sys_rstn, 1);
        vlow <= 1'b1;
        tick(60);
        chk(sys_rstn, 0);
        vlow <= 1'b0;
        tick(70);
        chk(sys_rstn, 1);
        chk(mode, 1);
        // Source 1 stands for a crystal here, so a nonzero gain is a fair pick.
        for (int i = 0; i < 8; i++) begin
            do_reset(i == 3, i, (i == 7) ? 8'h29 : 8'h14, i);
            tick(2);
            chk(stages, gtab[i]);
            chk(lvl, i % 4);
            chk(lvd_en, i % 4 != 2);
            chk(clk_ext, i == 3);
            chk(trim, (i == 7) ? 8'h29 : 8'h14);
            if (i == 7) chk(osc_run, 0);
            else if (i == 3) chk(lat >= 48 && lat <= 56, 1);
            else chk(lat >= 16 && lat <= 24, 1);
        end
        final_report;
    end
endmodule
